// File: rtl/rcs_regulator_regs.sv
// Regulator status and settings registers behind a sampled I2C target port
`timescale 1ns/1ps
`include "rcs_consts.svh"
// Contract
// - Each fault flag sets on its event and holds until cleared.
// - Flags clear only by command bit 0 write or power-on reset.
// - Live status bits follow their condition with no latching.
// - After reset status reads zero except bit 2 and no-fault bit 1.
// - Status bit 7 latches on an overcurrent event.
// - Bit 6 latches on thermal shutdown, bit 5 on thermal warning.
// - Bit 3 shows the enable pin, bit 0 the power-good output, live.
// - Status bit 4 always reads zero.
// - First settings bits 7:6 pick the 2A, 3A, 4A or 5A limit.
// - First settings bits 5:3 pick 310 to 1200 kHz switching.
// - Unused settings bits read zero and ignore writes.
// - Second settings bits 6:4 pick the start delay, 0 to 10 ms.
// - Bits 3:2 pick margin: nominal, minus 5, plus 5; live changes.
// - Margin always powers up as 00.
// - Bits 1:0 pick the reference soft-start slope.
// - Output-level code decodes in four ranges of 5, 10, 30, 50 mV.
// - Settings load factory defaults at power-on; writes are volatile.
// - Enable pin never resets the registers; only power-on reset does.
// - Writing command bit 0 clears flags, then the bit reads zero.
// - Command bits 7:1 have no effect.
module rcs_regulator_regs import rcs_pkg::*; #(
  parameter logic [6:0] I2C_ADDR       = `RCS_I2C_ADDR,
  parameter logic [1:0] DEF_LIMIT      = `RCS_DEF_LIMIT,
  parameter logic [2:0] DEF_RATE       = `RCS_DEF_RATE,
  parameter logic [2:0] DEF_WAIT       = `RCS_DEF_WAIT,
  parameter logic [1:0] DEF_SLOPE      = `RCS_DEF_SLOPE,
  parameter logic [7:0] DEF_LEVEL      = `RCS_DEF_LEVEL,
  parameter int unsigned HALF_MS_CYCLES = `RCS_HALF_MS_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        sclPin,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        enablePin,
  input  wire logic        powerGoodOutput,
  input  wire logic        overcurrentEvent,
  input  wire logic        thermalShutdownEvent,
  input  wire logic        thermalWarningEvent,
  output logic [1:0]       currentLimitSelect,
  output logic [2:0]       switchingRateSelect,
  output logic [2:0]       startupWaitSelect,
  output logic [1:0]       marginSelect,
  output logic [1:0]       rampSlopeSelect,
  output logic [7:0]       targetLevelCode,
  output logic [12:0]      targetLevelMv,
  output logic [10:0]      switchingKhz,
  output logic [2:0]       nominalLoadAmps,
  output logic             powerDeliveryEnable
);
  // Output level in millivolts for a code
  function automatic logic [12:0] levelToMv(input logic [7:0] code);
    int unsigned c;
    c = int'(code);
    if (code <= `RCS_LVL_TOP0) begin
      return 13'(`RCS_LVL_BASE0 + `RCS_LVL_STEP0 * c);
    end else if (code <= `RCS_LVL_TOP1) begin
      return 13'(`RCS_LVL_BASE1 + `RCS_LVL_STEP1 * (c - `RCS_LVL_FIRST1));
    end else if (code <= `RCS_LVL_TOP2) begin
      return 13'(`RCS_LVL_BASE2 + `RCS_LVL_STEP2 * (c - `RCS_LVL_FIRST2));
    end else begin
      return 13'(`RCS_LVL_BASE3 + `RCS_LVL_STEP3 * (c - `RCS_LVL_FIRST3));
    end
  endfunction

  // Switching frequency in kHz for a code
  function automatic logic [10:0] rateToKhz(input logic [2:0] code);
    case (code)
      3'h0:    return 11'h136;
      3'h1:    return 11'h190;
      3'h2:    return 11'h1F4;
      3'h3:    return 11'h23A;
      3'h4:    return 11'h294;
      3'h5:    return 11'h30C;
      3'h6:    return 11'h3CA;
      default: return 11'h4B0;
    endcase
  endfunction

  // Start delay in half-millisecond units for a code
  function automatic int unsigned delayUnits(input logic [2:0] code);
    case (code)
      3'h0:    return 0;
      3'h1:    return 1;
      3'h2:    return 2;
      3'h3:    return 4;
      3'h4:    return 8;
      3'h5:    return 12;
      3'h6:    return 16;
      default: return 20;
    endcase
  endfunction

  // Read data for a register address
  function automatic logic [7:0] readReg(input logic [7:0] addr, input logic [7:0] st,
                                         input rcs_top_state_t s);
    case (addr)
      `RCS_OFF_STATUS: return st;
      `RCS_OFF_LIMIT:  return {s.limit, s.rate, 3'h0};
      `RCS_OFF_DELAY:  return {1'b0, s.startWait, s.margin, s.slope};
      `RCS_OFF_LEVEL:  return s.level;
      `RCS_OFF_CMD:    return {7'h00, s.clearReq};
      default:         return 8'h00;
    endcase
  endfunction

  localparam rcs_top_state_t RESET_STATE = '{
    state: ST_IDLE, limit: DEF_LIMIT, rate: DEF_RATE, startWait: DEF_WAIT,
    margin: `RCS_MARGIN_POR, slope: DEF_SLOPE, level: DEF_LEVEL,
    levelMv: levelToMv(DEF_LEVEL), rateKhz: rateToKhz(DEF_RATE),
    loadAmps: 3'(DEF_LIMIT) + 3'h2, default: '0};

  rcs_top_state_t q;
  rcs_top_state_t n;
  logic [6:0]     syncIn;
  logic [6:0]     syncOut;
  logic           sclLevel;
  logic           sdaLevel;
  logic           enableInputLevel;
  logic           powerGoodLevel;
  rcs_flags_t     faultEvents;
  logic           sclRise;
  logic           sclFall;
  logic           startCond;
  logic           stopCond;
  logic [7:0]     statusByte;
  logic [7:0]     rdData;
  logic [20:0]    waitTarget;
  logic           wrEn;
  logic [7:0]     wrAddr;
  logic [7:0]     wrData;

  rcs_flag_if flagBus ();

  // Pins and fault events from the analog side
  assign syncIn = {sclPin, sdaIn, enablePin, powerGoodOutput,
                   overcurrentEvent, thermalShutdownEvent, thermalWarningEvent};

  rcs_sync #(.WIDTH(7)) pinSync (
    .core_clk (core_clk),
    .reset    (reset),
    .asyncIn  (syncIn),
    .syncOut  (syncOut)
  );

  assign {sclLevel, sdaLevel, enableInputLevel, powerGoodLevel} = syncOut[6:3];
  assign faultEvents = rcs_flags_t'(syncOut[2:0]);

  rcs_fault_latch flagLatch (
    .core_clk (core_clk),
    .reset    (reset),
    .flagBus  (flagBus)
  );

  assign flagBus.events = faultEvents;
  assign flagBus.clear  = q.clearReq;

  // Bus conditions seen on the sampled pins
  assign sclRise   = sclLevel & ~q.sclPrev;
  assign sclFall   = ~sclLevel & q.sclPrev;
  assign startCond = sclLevel & q.sclPrev & q.sdaPrev & ~sdaLevel;
  assign stopCond  = sclLevel & q.sclPrev & ~q.sdaPrev & sdaLevel;

  // Status: latched flags, live pin levels, fixed bits
  assign statusByte = {flagBus.flags.overcurrent, flagBus.flags.thermalShutdown,
                       flagBus.flags.thermalWarning, 1'b0,
                       enableInputLevel, 1'b1, ~|flagBus.flags,
                       powerGoodLevel};
  assign rdData     = readReg(q.ptr, statusByte, q);
  assign waitTarget = 21'(delayUnits(q.startWait) * HALF_MS_CYCLES);

  // Target engine, register writes, start timer and decodes
  always_comb begin
    n         = q;
    wrEn      = 1'b0;
    wrAddr    = q.ptr;
    wrData    = q.shift;
    n.sclPrev = sclLevel;
    n.sdaPrev = sdaLevel;
    n.sdaLow  = 1'b0;
    n.clearReq = 1'b0;
    case (q.state)
      ST_IDLE: begin
        n.sdaOe = 1'b0;
      end
      ST_ADDR: begin
        if (sclRise) begin
          n.shift  = {q.shift[6:0], sdaLevel};
          n.bitCnt = q.bitCnt + 4'h1;
        end else if (sclFall && q.bitCnt == 4'h8) begin
          if (q.shift[7:1] == I2C_ADDR) begin
            n.sdaOe    = 1'b1;
            n.readMode = q.shift[0];
            n.state    = ST_ADDR_ACK;
          end else begin
            n.state = ST_IDLE;
          end
        end
      end
      ST_ADDR_ACK: begin
        if (sclFall) begin
          n.bitCnt = 4'h0;
          if (q.readMode) begin
            n.shift = rdData;
            n.sdaOe = ~rdData[7];
            n.state = ST_READ;
          end else begin
            n.sdaOe     = 1'b0;
            n.firstByte = 1'b1;
            n.state     = ST_WRITE;
          end
        end
      end
      ST_WRITE: begin
        if (sclRise) begin
          n.shift  = {q.shift[6:0], sdaLevel};
          n.bitCnt = q.bitCnt + 4'h1;
        end else if (sclFall && q.bitCnt == 4'h8) begin
          n.sdaOe = 1'b1;
          n.state = ST_WRITE_ACK;
          if (q.firstByte) begin
            n.ptr       = q.shift;
            n.firstByte = 1'b0;
          end else begin
            wrEn  = 1'b1;
            n.ptr = q.ptr + 8'h01;
          end
        end
      end
      ST_WRITE_ACK: begin
        if (sclFall) begin
          n.sdaOe  = 1'b0;
          n.bitCnt = 4'h0;
          n.state  = ST_WRITE;
        end
      end
      ST_READ: begin
        if (sclRise) begin
          n.bitCnt = q.bitCnt + 4'h1;
        end else if (sclFall) begin
          if (q.bitCnt == 4'h8) begin
            n.sdaOe = 1'b0;
            n.state = ST_READ_ACK;
          end else begin
            n.shift = {q.shift[6:0], 1'b0};
            n.sdaOe = ~q.shift[6];
          end
        end
      end
      ST_READ_ACK: begin
        if (sclRise) begin
          if (sdaLevel) begin
            n.state = ST_IDLE;
          end else begin
            n.ptr = q.ptr + 8'h01;
          end
        end else if (sclFall) begin
          n.shift  = rdData;
          n.sdaOe  = ~rdData[7];
          n.bitCnt = 4'h0;
          n.state  = ST_READ;
        end
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase
    if (startCond) begin
      n.state  = ST_ADDR;
      n.bitCnt = 4'h0;
      n.sdaOe  = 1'b0;
    end else if (stopCond) begin
      n.state = ST_IDLE;
      n.sdaOe = 1'b0;
    end
    // Register writes; the enable pin has no reset path here
    if (wrEn) begin
      case (wrAddr)
        `RCS_OFF_LIMIT: begin
          n.limit = wrData[`RCS_LIM_LSB +: 2];
          n.rate  = wrData[`RCS_FRQ_LSB +: 3];
        end
        `RCS_OFF_DELAY: begin
          n.startWait = wrData[`RCS_DLY_LSB +: 3];
          n.margin    = wrData[`RCS_MRG_LSB +: 2];
          n.slope     = wrData[`RCS_SLP_LSB +: 2];
        end
        `RCS_OFF_LEVEL: begin
          n.level = wrData;
        end
        `RCS_OFF_CMD: begin
          n.clearReq = wrData[`RCS_CMD_CLR];
        end
        default: begin
          n.level = q.level;
        end
      endcase
    end
    // Start delay from the enable rising edge to power delivery
    n.enPrev = enableInputLevel;
    if (!enableInputLevel) begin
      n.waitRun = 1'b0;
      n.powerOn = 1'b0;
    end else if (!q.enPrev) begin
      n.waitRun = 1'b1;
      n.waitCnt = 21'h000000;
    end else if (q.waitRun) begin
      if (q.waitCnt >= waitTarget) begin
        n.powerOn = 1'b1;
        n.waitRun = 1'b0;
      end else begin
        n.waitCnt = q.waitCnt + 21'h000001;
      end
    end
    n.levelMv  = levelToMv(q.level);
    n.rateKhz  = rateToKhz(q.rate);
    n.loadAmps = 3'(q.limit) + 3'h2;
  end

  // Power-on reset loads factory defaults and margin 00
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= RESET_STATE;
    end else begin
      q <= n;
    end
  end

  assign sdaOut              = q.sdaLow;
  assign sdaOe               = q.sdaOe;
  assign currentLimitSelect  = q.limit;
  assign switchingRateSelect = q.rate;
  assign startupWaitSelect   = q.startWait;
  assign marginSelect        = q.margin;
  assign rampSlopeSelect     = q.slope;
  assign targetLevelCode     = q.level;
  assign targetLevelMv       = q.levelMv;
  assign switchingKhz        = q.rateKhz;
  assign nominalLoadAmps     = q.loadAmps;
  assign powerDeliveryEnable = q.powerOn;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_clear_cmd;
    (wrEn && wrAddr == `RCS_OFF_CMD && wrData[0]) |=> q.clearReq ##1
      (flagBus.flags == $past(faultEvents)) && !q.clearReq;
  endproperty
  a_clear_cmd: assert property (p_clear_cmd)
    else $error("Clear command did not clear flags and self-clear");

  property p_cmd_upper;
    (wrEn && wrAddr == `RCS_OFF_CMD && !wrData[0]) |=> !q.clearReq;
  endproperty
  a_cmd_upper: assert property (p_cmd_upper)
    else $error("Upper command bits caused an action");

  property p_status_por;
    $past(reset) |-> statusByte == 8'h06;
  endproperty
  a_status_por: assert property (p_status_por)
    else $error("Status after reset is not 06h");

  property p_status_fixed;
    !statusByte[4] && statusByte[2] && (statusByte[1] == (flagBus.flags == 3'h0));
  endproperty
  a_status_fixed: assert property (p_status_fixed)
    else $error("Fixed status bits wrong");

  property p_enable_live;
    $fell(enableInputLevel) |-> !statusByte[3] && !rdData[3] || q.ptr != `RCS_OFF_STATUS;
  endproperty
  a_enable_live: assert property (p_enable_live)
    else $error("Enable status bit not live");

  property p_limit_write;
    (wrEn && wrAddr == `RCS_OFF_LIMIT) |=> q.limit == $past(wrData[7:6]) &&
      readReg(`RCS_OFF_LIMIT, statusByte, q) == {$past(wrData[7:3]), 3'h0};
  endproperty
  a_limit_write: assert property (p_limit_write)
    else $error("Limit write or reserved bits wrong");

  property p_level_decode;
    (q.level == 8'hC4 |=> targetLevelMv == 13'h07BC) and
    (q.level == 8'hF5 |=> targetLevelMv == 13'h128E);
  endproperty
  a_level_decode: assert property (p_level_decode)
    else $error("Level code decode wrong");

  property p_margin_por;
    $past(reset) |-> marginSelect == 2'h0;
  endproperty
  a_margin_por: assert property (p_margin_por)
    else $error("Margin not 00 after reset");

  property p_enable_no_reset;
    ($fell(enableInputLevel) && !wrEn) |=> $stable(targetLevelCode) && $stable(currentLimitSelect);
  endproperty
  a_enable_no_reset: assert property (p_enable_no_reset)
    else $error("Enable pin disturbed settings");

  property p_zero_delay;
    ($rose(enableInputLevel) && q.startWait == 3'h0) ##1 enableInputLevel |=> powerDeliveryEnable;
  endproperty
  a_zero_delay: assert property (p_zero_delay)
    else $error("Zero start delay not honoured");

  c_read_status: cover property (q.state == ST_READ && q.ptr == `RCS_OFF_STATUS);
  c_level_write: cover property (wrEn && wrAddr == `RCS_OFF_LEVEL);
  c_power_on: cover property ($rose(powerDeliveryEnable));
endmodule // rcs_regulator_regs

// File: rtl/rcs_consts.svh
// Register offsets, field positions, reset values and timing of the regulator registers
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH
`define RCS_OFF_STATUS      8'h00
`define RCS_OFF_LIMIT       8'h01
`define RCS_OFF_DELAY       8'h02
`define RCS_OFF_LEVEL       8'h03
`define RCS_OFF_CMD         8'h04
`define RCS_ST_NOFAULT      1
`define RCS_LIM_LSB         6
`define RCS_FRQ_LSB         3
`define RCS_DLY_LSB         4
`define RCS_MRG_LSB         2
`define RCS_SLP_LSB         0
`define RCS_CMD_CLR         0
`define RCS_DEF_LIMIT       2'h0
`define RCS_DEF_RATE        3'h0
`define RCS_DEF_WAIT        3'h0
`define RCS_DEF_SLOPE       2'h0
`define RCS_DEF_LEVEL       8'h00
`define RCS_MARGIN_POR      2'h0
`define RCS_I2C_ADDR        7'h50
`define RCS_LVL_TOP0        8'h80
`define RCS_LVL_TOP1        8'hC3
`define RCS_LVL_TOP2        8'hF4
`define RCS_LVL_FIRST1      129
`define RCS_LVL_FIRST2      196
`define RCS_LVL_FIRST3      245
`define RCS_LVL_BASE0       640
`define RCS_LVL_BASE1       1290
`define RCS_LVL_BASE2       1980
`define RCS_LVL_BASE3       4750
`define RCS_LVL_STEP0       5
`define RCS_LVL_STEP1       10
`define RCS_LVL_STEP2       30
`define RCS_LVL_STEP3       50
`define RCS_CLK_PERIOD_NS   10
`define RCS_HALF_MS_NS      500000
`define RCS_HALF_MS_CYCLES  (`RCS_HALF_MS_NS / `RCS_CLK_PERIOD_NS)
`endif

// File: rtl/rcs_pkg.sv
// Types shared by the regulator register block
package rcs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_ADDR      = 3'b001,
    ST_ADDR_ACK  = 3'b010,
    ST_WRITE     = 3'b011,
    ST_WRITE_ACK = 3'b100,
    ST_READ      = 3'b101,
    ST_READ_ACK  = 3'b110
  } rcs_i2c_state_t;

  typedef struct packed {
    logic overcurrent;
    logic thermalShutdown;
    logic thermalWarning;
  } rcs_flags_t;

  typedef struct packed {
    rcs_i2c_state_t state;
    logic [3:0]     bitCnt;
    logic [7:0]     shift;
    logic [7:0]     ptr;
    logic           firstByte;
    logic           readMode;
    logic           sclPrev;
    logic           sdaPrev;
    logic           sdaOe;
    logic           sdaLow;
    logic [1:0]     limit;
    logic [2:0]     rate;
    logic [2:0]     startWait;
    logic [1:0]     margin;
    logic [1:0]     slope;
    logic [7:0]     level;
    logic           clearReq;
    logic           enPrev;
    logic [20:0]    waitCnt;
    logic           waitRun;
    logic           powerOn;
    logic [12:0]    levelMv;
    logic [10:0]    rateKhz;
    logic [2:0]     loadAmps;
  } rcs_top_state_t;
endpackage

// File: rtl/rcs_flag_if.sv
// Fault events, clear request and latched flags between register logic and flag latch
`timescale 1ns/1ps
interface rcs_flag_if import rcs_pkg::*; ();
  rcs_flags_t events;
  rcs_flags_t flags;
  logic       clear;
  modport latch (input events, input clear, output flags);
  modport user  (output events, output clear, input flags);
endinterface

// File: rtl/rcs_sync.sv
// Two-flop synchroniser for pins from outside the core clock domain
`timescale 1ns/1ps
module rcs_sync #(
  parameter int unsigned WIDTH = 7
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } rcs_sync_state_t;

  rcs_sync_state_t q;
  rcs_sync_state_t n;

  // First stage feeds only the second
  always_comb begin
    n        = q;
    n.meta   = asyncIn;
    n.stable = q.meta;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign syncOut = q.stable;
endmodule // rcs_sync

// File: rtl/rcs_fault_latch.sv
// Sticky fault flags; a new event wins over a clear in the same cycle
`timescale 1ns/1ps
module rcs_fault_latch import rcs_pkg::*; (
  input  wire logic core_clk,
  input  wire logic reset,
  rcs_flag_if.latch flagBus
);
  typedef struct packed {
    rcs_flags_t flags;
  } rcs_latch_state_t;

  rcs_latch_state_t q;
  rcs_latch_state_t n;

  // Hold, clear on request, set by any event
  always_comb begin
    n       = q;
    n.flags = rcs_flags_t'((flagBus.clear ? 3'h0 : q.flags) | flagBus.events);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign flagBus.flags = q.flags;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_flag_sticky;
    q.flags.overcurrent && !flagBus.clear |=> q.flags.overcurrent;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("Overcurrent flag dropped without a clear");

  property p_oc_set;
    flagBus.events.overcurrent |=> q.flags.overcurrent;
  endproperty
  a_oc_set: assert property (p_oc_set)
    else $error("Overcurrent event not latched");

  property p_thermal_set;
    (flagBus.events.thermalShutdown |=> q.flags.thermalShutdown) and
      (flagBus.events.thermalWarning |=> q.flags.thermalWarning);
  endproperty
  a_thermal_set: assert property (p_thermal_set)
    else $error("Thermal events not latched");

  property p_clear_only;
    $fell(q.flags.overcurrent) || $fell(q.flags.thermalShutdown) ||
      $fell(q.flags.thermalWarning) |-> $past(flagBus.clear);
  endproperty
  a_clear_only: assert property (p_clear_only)
    else $error("Fault flag fell without a clear");

  c_cleared: cover property (q.flags.overcurrent ##1 !q.flags.overcurrent);
endmodule // rcs_fault_latch

// File: bench/rcs_i2c_host.sv
// I2C host model for the register port
`timescale 1ns/1ps
`include "rcs_consts.svh"
module rcs_i2c_host (
  output logic      sclPin,
  output logic      sdaDrv,
  input  wire logic sdaWire
);
  // Bus idles released, clock standing high
  initial begin
    sclPin = 1'b1;
    sdaDrv = 1'b1;
  end
  // One bit: data moves only while the clock is low
  task automatic bitx(input logic b, output logic r);
    #10 sdaDrv = b;
    #30 sclPin = 1'b1;
    #40 r = sdaWire;
    sclPin = 1'b0;
  endtask
  // Start or repeated start: data falls with the clock high
  task automatic start();
    #10 sdaDrv = 1'b1;
    #30 sclPin = 1'b1;
    #40 sdaDrv = 1'b0;
    #40 sclPin = 1'b0;
  endtask
  // Stop: data rises with the clock high
  task automatic stop();
    #10 sdaDrv = 1'b0;
    #30 sclPin = 1'b1;
    #40 sdaDrv = 1'b1;
    #40;
  endtask
  // Byte MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ao, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--)
      bitx(tx[i], rx[i]);
    bitx(ao, ack);
  endtask
  // Single-register write
  task automatic wr(input logic [7:0] ra, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2;
    start();
    xfer({`RCS_I2C_ADDR, 1'b0}, 1'b1, rx, a0);
    xfer(ra, 1'b1, rx, a1);
    xfer(d, 1'b1, rx, a2);
    stop();
    ok = !(a0 | a1 | a2);
  endtask
  // Pointer write, repeated start, one byte read closed by a NACK
  task automatic rd(input logic [7:0] ra, output logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2, a3;
    start();
    xfer({`RCS_I2C_ADDR, 1'b0}, 1'b1, rx, a0);
    xfer(ra, 1'b1, rx, a1);
    start();
    xfer({`RCS_I2C_ADDR, 1'b1}, 1'b1, rx, a2);
    xfer(8'hFF, 1'b1, d, a3);
    stop();
    ok = !(a0 | a1 | a2);
  endtask
  // Two-byte read: host ACKs the first byte, NACKs the second
  task automatic rd2(input logic [7:0] ra, output logic [15:0] d, output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2, a3, a4;
    start();
    xfer({`RCS_I2C_ADDR, 1'b0}, 1'b1, rx, a0);
    xfer(ra, 1'b1, rx, a1);
    start();
    xfer({`RCS_I2C_ADDR, 1'b1}, 1'b1, rx, a2);
    xfer(8'hFF, 1'b0, d[15:8], a3);
    xfer(8'hFF, 1'b1, d[7:0], a4);
    stop();
    ok = !(a0 | a1 | a2);
  endtask
endmodule // rcs_i2c_host

// File: bench/tb.sv
// Self-checking bench for the regulator register block
`timescale 1ns/1ps
`include "rcs_consts.svh"
module tb;
  logic        core_clk, reset, enablePin, pgOut, sdaOe, pde, sdaDat;
  logic [2:0]  evts, rateSel, waitSel, amps;
  logic [1:0]  limSel, mrgSel, slpSel;
  logic [7:0]  lvlCode;
  logic [12:0] lvlMv;
  logic [10:0] khz;
  wire         sclPin, sdaDrv;
  wire         sdaWire = sdaDrv & ~(sdaOe & ~sdaDat);
  int          miscompares = 0;
  int          checked = 0;
  int          khzTab[8] = '{310, 400, 500, 570, 660, 780, 970, 1200};
  int          unitTab[8] = '{0, 1, 2, 4, 8, 12, 16, 20};
  logic [7:0]  lvlTab[8] = '{8'h00, 8'h80, 8'h81, 8'hC3, 8'hC4, 8'hF4, 8'hF5, 8'hFF};
  rcs_i2c_host rcs_i2c_host_i (.sclPin(sclPin), .sdaDrv(sdaDrv), .sdaWire(sdaWire));
  rcs_regulator_regs #(.HALF_MS_CYCLES(4)) rcs_regulator_regs_i (
    .core_clk(core_clk), .reset(reset), .sclPin(sclPin), .sdaIn(sdaWire), .sdaOut(sdaDat),
    .sdaOe(sdaOe), .enablePin(enablePin), .powerGoodOutput(pgOut),
    .overcurrentEvent(evts[2]), .thermalShutdownEvent(evts[1]), .thermalWarningEvent(evts[0]),
    .currentLimitSelect(limSel), .switchingRateSelect(rateSel), .startupWaitSelect(waitSel),
    .marginSelect(mrgSel), .rampSlopeSelect(slpSel), .targetLevelCode(lvlCode),
    .targetLevelMv(lvlMv), .switchingKhz(khz), .nominalLoadAmps(amps),
    .powerDeliveryEnable(pde));
  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] ra, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    rcs_i2c_host_i.rd(ra, d, ok);
    chk({7'h00, ok, d}, {8'h01, exp});
  endtask
  task automatic wchk(input logic [7:0] ra, input logic [7:0] d);
    logic ok;
    rcs_i2c_host_i.wr(ra, d, ok);
    chk({15'h0000, ok}, 16'h0001);
  endtask
  task automatic ev(input logic [2:0] v);
    evts = v;
    tick(4);
    evts = 3'h0;
    tick(4);
  endtask
  // Millivolts from the code, four ranges
  function automatic int mvOf(input logic [7:0] c);
    if (c <= 8'h80) return 640 + 5 * c;
    if (c <= 8'hC3) return 1290 + 10 * (c - 129);
    if (c <= 8'hF4) return 1980 + 30 * (c - 196);
    return 4750 + 50 * (c - 245);
  endfunction
  task automatic t_defaults();
    rchk(`RCS_OFF_STATUS, 8'h06);
    rchk(`RCS_OFF_LIMIT, 8'h00);
    rchk(`RCS_OFF_DELAY, 8'h00);
    rchk(`RCS_OFF_LEVEL, 8'h00);
    chk({lvlMv, amps}, {13'(mvOf(8'h00)), 3'h2});
    $display("defaults test done");
  endtask
  task automatic t_flags();
    ev(3'h4);
    rchk(`RCS_OFF_STATUS, 8'h84);
    ev(3'h2);
    rchk(`RCS_OFF_STATUS, 8'hC4);
    ev(3'h1);
    rchk(`RCS_OFF_STATUS, 8'hE4);
    wchk(`RCS_OFF_CMD, 8'hFE);
    rchk(`RCS_OFF_STATUS, 8'hE4);
    wchk(`RCS_OFF_CMD, 8'h01);
    rchk(`RCS_OFF_STATUS, 8'h06);
    rchk(`RCS_OFF_CMD, 8'h00);
    enablePin = 1'b1;
    pgOut = 1'b1;
    rchk(`RCS_OFF_STATUS, 8'h0F);
    enablePin = 1'b0;
    pgOut = 1'b0;
    rchk(`RCS_OFF_STATUS, 8'h06);
    rchk(8'h05, 8'h00);
    $display("flags test done");
  endtask
  task automatic t_settings();
    logic [15:0] d2;
    logic        ok2;
    // Enable stays low while non-margin fields change
    for (int i = 0; i < 8; i++) begin
      wchk(`RCS_OFF_LIMIT, {i[1:0], i[2:0], 3'h7});
      tick(2);
      chk({limSel, rateSel, khz}, {i[1:0], i[2:0], 11'(khzTab[i])});
      chk({13'h0000, amps}, 16'(2 + i[1:0]));
    end
    rchk(`RCS_OFF_LIMIT, 8'hF8);
    rcs_i2c_host_i.rd2(`RCS_OFF_LIMIT, d2, ok2);
    chk(d2, 16'hF800);
    chk({15'h0000, ok2}, 16'h0001);
    $display("settings test done");
  endtask
  task automatic t_delay();
    int n;
    for (int k = 0; k < 8; k++) begin
      wchk(`RCS_OFF_DELAY, {1'b1, k[2:0], k[1:0], k[1:0]});
      chk({waitSel, mrgSel, slpSel}, {9'h000, k[2:0], k[1:0], k[1:0]});
      enablePin = 1'b1;
      n = 0;
      while (pde !== 1'b1 && n < 200) begin
        tick(1);
        n++;
      end
      if (n == 200) begin
        miscompares++;
        results();
      end
      chk({15'h0000, n >= 4 * unitTab[k] + 3 && n <= 4 * unitTab[k] + 5}, 16'h0001);
      wchk(`RCS_OFF_DELAY, {1'b1, k[2:0], ~k[1:0], k[1:0]});
      chk({13'h0000, mrgSel, pde}, {13'h0000, ~k[1:0], 1'b1});
      enablePin = 1'b0;
      tick(4);
      chk({15'h0000, pde}, 16'h0000);
      rchk(`RCS_OFF_DELAY, {1'b0, k[2:0], ~k[1:0], k[1:0]});
    end
    $display("delay test done");
  endtask
  task automatic t_level();
    // Enable is low, so crossing ranges is allowed here
    for (int j = 0; j < 8; j++) begin
      wchk(`RCS_OFF_LEVEL, lvlTab[j]);
      tick(2);
      chk({8'h00, lvlCode}, {8'h00, lvlTab[j]});
      chk({3'h0, lvlMv}, 16'(mvOf(lvlTab[j])));
    end
    ev(3'h4);
    reset = 1'b1;
    tick(4);
    reset = 1'b0;
    tick(3);
    rchk(`RCS_OFF_STATUS, 8'h06);
    rchk(`RCS_OFF_LEVEL, 8'h00);
    rchk(`RCS_OFF_DELAY, 8'h00);
    $display("level and power-on test done");
  endtask
  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    enablePin = 1'b0;
    pgOut = 1'b0;
    evts = 3'h0;
    tick(12);
    reset = 1'b0;
    tick(3);
    t_defaults();
    t_flags();
    t_settings();
    t_delay();
    t_level();
    results();
  end
endmodule // tb
